// file: include/dpt_pkg.sv
// dpt_pkg: shared constants and types for the dual pulse timer
// assumes a single 250 MHz core clock (the doubled input clock)
package dpt_pkg;

  // counter geometry
  localparam int          TMR_W      = 32;
  localparam logic [31:0] CNT_RELOAD = 32'h0000_0001;
  localparam logic [31:0] CNT_FULL   = 32'hFFFF_FFFF;

  // io-processor register addresses
  localparam int          IOP_AW        = 8;
  localparam logic [7:0]  ADDR_PERIOD0  = 8'h28;
  localparam logic [7:0]  ADDR_WIDTH0   = 8'h29;
  localparam logic [7:0]  ADDR_COUNT0   = 8'h2A;
  localparam logic [7:0]  ADDR_PERIOD1  = 8'h2B;
  localparam logic [7:0]  ADDR_WIDTH1   = 8'h2C;
  localparam logic [7:0]  ADDR_COUNT1   = 8'h2D;

  // sticky status layout
  localparam int          STICKY_STATUS_REG_W    = 16;
  localparam int          STICKY_STATUS_REG_CAP0 = 12;
  localparam int          STICKY_STATUS_REG_EXP0 = 13;
  localparam int          STICKY_STATUS_REG_CAP1 = 14;
  localparam int          STICKY_STATUS_REG_EXP1 = 15;
  localparam logic [15:0] STICKY_STATUS_REG_RST  = 16'h0000;

  // which timer register an address selects
  typedef enum logic [1:0] {
    DPT_SEL_PERIOD,
    DPT_SEL_WIDTH,
    DPT_SEL_COUNT,
    DPT_SEL_NONE
  } dpt_sel_t;

endpackage

// file: include/dpt_tmr_if.sv
// dpt_tmr_if: carrier between the timer top and one timer channel
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface dpt_tmr_if;
  // control from the top
  logic        run;
  logic        wave_mode;
  logic        polarity;
  logic        cap_sel;
  logic        wr_per;
  logic        wr_wid;
  logic [31:0] wdata;
  logic        pin_in;
  // state from the channel
  logic [31:0] per;
  logic [31:0] wid;
  logic [31:0] cnt;
  logic        exp_evt;
  logic        cap_evt;
  logic        pin_out;
  logic        pin_oe;

  modport ctl  (output run, wave_mode, polarity, cap_sel, wr_per, wr_wid, wdata, pin_in,
                input  per, wid, cnt, exp_evt, cap_evt, pin_out, pin_oe);
  modport chan (input  run, wave_mode, polarity, cap_sel, wr_per, wr_wid, wdata, pin_in,
                output per, wid, cnt, exp_evt, cap_evt, pin_out, pin_oe);
endinterface

// file: core/dpt_timer_chan.sv
// dpt_timer_chan: one 32-bit timer, waveform output or pulse measure
// assumes mode bits come from logic on the same clock; pin input is async
`timescale 1ns/1ps
module dpt_timer_chan (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // link to the top
  dpt_tmr_if.chan   tif
);

  // short local names for the reload and park values
  localparam logic [31:0] CNT_RELOAD_C = dpt_pkg::CNT_RELOAD;
  localparam logic [31:0] CNT_FULL_C   = dpt_pkg::CNT_FULL;

  logic        sync1_q, sync2_q, sync3_q;
  logic        lvl_q, lvl_d, lvl_prev_q;
  logic [31:0] cnt_q, cnt_d, per_q, per_d, wid_q, wid_d;
  logic        pin_q, pin_d, oe_q, oe_d, run_q;
  logic        exp_q, exp_d, cap_q, cap_d, armed_q, armed_d;
  logic        rise, fall, lead, trail, wr_ok;

  // filtered level moves only when the last two stages agree
  always_comb begin
    lvl_d = (sync2_q == sync3_q) ? sync3_q : lvl_q;
  end

  // three-stage pin synchroniser, first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      sync3_q    <= 1'b0;
      lvl_q      <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else begin
      sync1_q    <= tif.pin_in;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      lvl_q      <= lvl_d;
      lvl_prev_q <= lvl_q;
    end
  end

  // edge decode, polarity picks which edge leads
  always_comb begin
    rise  = lvl_q & ~lvl_prev_q;
    fall  = ~lvl_q & lvl_prev_q;
    lead  = tif.polarity ? fall : rise;
    trail = tif.polarity ? rise : fall;
    wr_ok = !(tif.run && !tif.wave_mode);
  end

  // next state of counter, captures, pin and events
  always_comb begin
    cnt_d   = cnt_q;
    per_d   = per_q;
    wid_d   = wid_q;
    pin_d   = pin_q;
    armed_d = armed_q;
    exp_d   = 1'b0;
    cap_d   = 1'b0;
    oe_d    = tif.wave_mode;
    // software loads; blocked while measuring
    if (tif.wr_per && wr_ok) begin
      per_d = tif.wdata;
    end
    if (tif.wr_wid && wr_ok) begin
      wid_d = tif.wdata;
    end
    if (tif.run && !run_q) begin
      cnt_d   = CNT_RELOAD_C;
      armed_d = 1'b1;
    end else if (tif.run && tif.wave_mode) begin
      if (cnt_q == per_q) begin
        cnt_d = CNT_RELOAD_C;
        pin_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CNT_RELOAD_C;
        if (cnt_q == wid_q) begin
          pin_d = 1'b1;
        end
      end
    end else if (tif.run) begin
      if (lead) begin
        per_d = cnt_q;
        cnt_d = CNT_RELOAD_C;
        if (tif.cap_sel) begin
          cap_d   = 1'b1;
          armed_d = 1'b1;
        end
      end else begin
        if (trail) begin
          wid_d = cnt_q;
          if (!tif.cap_sel) begin
            cap_d   = 1'b1;
            armed_d = 1'b1;
          end
        end
        // counter parks at all ones; one overflow per capture window
        if (cnt_q == CNT_FULL_C) begin
          if (armed_q) begin
            exp_d   = 1'b1;
            armed_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q + CNT_RELOAD_C;
        end
      end
    end
    // run low: counter, pin and arm hold; period and width still take writes
  end

  // timer registers; count, period and width start at one, not to be relied on
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q   <= dpt_pkg::CNT_RELOAD;
      per_q   <= dpt_pkg::CNT_RELOAD;
      wid_q   <= dpt_pkg::CNT_RELOAD;
      pin_q   <= 1'b0;
      oe_q    <= 1'b0;
      run_q   <= 1'b0;
      exp_q   <= 1'b0;
      cap_q   <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      per_q   <= per_d;
      wid_q   <= wid_d;
      pin_q   <= pin_d;
      oe_q    <= oe_d;
      run_q   <= tif.run;
      exp_q   <= exp_d;
      cap_q   <= cap_d;
      armed_q <= armed_d;
    end
  end

  assign tif.cnt     = cnt_q;
  assign tif.per     = per_q;
  assign tif.wid     = wid_q;
  assign tif.pin_out = pin_q;
  assign tif.pin_oe  = oe_q;
  assign tif.exp_evt = exp_q;
  assign tif.cap_evt = cap_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_period_reload: assert property (
    tif.run && run_q && tif.wave_mode && cnt_q == per_q |=> cnt_q == dpt_pkg::CNT_RELOAD)
    else $error("count not reloaded at period");
  chk_pin_low_exp: assert property (
    tif.run && run_q && tif.wave_mode && cnt_q == per_q |=> !tif.pin_out && tif.exp_evt)
    else $error("period match did not drop pin and flag expiry");
  chk_pin_high_width: assert property (
    tif.run && run_q && tif.wave_mode && cnt_q == wid_q && cnt_q != per_q |=> tif.pin_out)
    else $error("width match did not raise pin");
  chk_lead_capture: assert property (
    tif.run && run_q && !tif.wave_mode && lead
    |=> cnt_q == dpt_pkg::CNT_RELOAD && per_q == $past(cnt_q))
    else $error("leading edge did not capture period and restart");
  chk_trail_capture: assert property (
    tif.run && run_q && !tif.wave_mode && trail |=> wid_q == $past(cnt_q))
    else $error("trailing edge did not capture width");
  chk_measure_ro: assert property (
    tif.run && !tif.wave_mode && tif.wr_per && !lead |=> $stable(per_q))
    else $error("period written while measuring");
  chk_stop_holds: assert property (
    !tif.run && !tif.wr_per && !tif.wr_wid
    |=> $stable(cnt_q) && $stable(pin_q) && !tif.exp_evt && !tif.cap_evt)
    else $error("stopped timer changed state");
  chk_overflow_once: assert property (
    tif.exp_evt && !tif.wave_mode |=> !tif.exp_evt)
    else $error("overflow flagged twice in a row");

endmodule

// file: core/dpt_top.sv
// dpt_top: two timers, io-processor register port, sticky flags, irq routing
// assumes mode bits and sticky clears come from core logic on this clock;
// event pins are asynchronous and are resolved outside from out/oe.
//
// Summary of operation
// - two identical timers, each mode-selectable
// - one event pin, output or input
// - 32-bit counters on doubled core clock
// - run bit starts and stops timer
// - output-mode select high picks waveform mode
// - pin low at period, high at width
// - counter loads one on enable, period
// - period match sets expiry flag, interrupt
// - expiry flag zero at reset, sticky
// - output-mode select low picks pulse measure
// - leading edge restarts count at one
// - trailing edge captures count into width
// - leading edge captures count into period
// - polarity bit chooses leading edge direction
// - period, width read-only while measuring
// - capture-select picks period or width flag
// - all-ones before capture sets overflow flag
// - capture and expiry flags stay until cleared
// - timer registers only on io-processor port
// - run gates counting, captures and flags; disabled after reset
// - vector select routes irq high/low, ORed
// - sticky bits twelve to fifteen hold flags
`timescale 1ns/1ps
module dpt_top (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // io-processor register port
  input  wire logic [7:0]  iop_addr_in,
  input  wire logic        iop_wr_in,
  input  wire logic [31:0] iop_wdata_in,
  input  wire logic        iop_rd_in,
  output logic      [31:0] iop_rdata_out,
  output logic             iop_rvalid_out,
  // timer mode control bits
  input  wire logic [1:0]  timer_run_bit_in,
  input  wire logic [1:0]  output_mode_select_in,
  input  wire logic [1:0]  edge_polarity_select_in,
  input  wire logic [1:0]  capture_select_bit_in,
  input  wire logic [1:0]  vector_select_bit_in,
  // sticky status
  input  wire logic [15:0] sticky_clr_in,
  output logic      [15:0] sticky_status_out,
  // interrupt latch requests
  output logic             high_prio_timer_irq_out,
  output logic             low_prio_timer_irq_out,
  // event pins
  input  wire logic [1:0]  timer_event_pin_in,
  output logic      [1:0]  timer_event_pin_out,
  output logic      [1:0]  timer_event_pin_oe_out
);

  logic [31:0] ch_per [2];
  logic [31:0] ch_wid [2];
  logic [31:0] ch_cnt [2];
  logic [1:0]  ch_exp, ch_cap;
  logic [1:0]  ch_pin, ch_oe;
  logic [15:0] sticky_q, sticky_d, sticky_set;
  logic [31:0] rdata_q, rdata_d;
  logic        rvalid_q, hi_irq_q, hi_irq_d, lo_irq_q, lo_irq_d;

  // address to channel index; ones above timer 0's block are timer 1
  function automatic logic addr_chan(input logic [7:0] a);
    addr_chan = (a >= dpt_pkg::ADDR_PERIOD1);
  endfunction

  // address to register select within a channel
  function automatic dpt_pkg::dpt_sel_t addr_sel(input logic [7:0] a);
    case (a)
      dpt_pkg::ADDR_PERIOD0, dpt_pkg::ADDR_PERIOD1: addr_sel = dpt_pkg::DPT_SEL_PERIOD;
      dpt_pkg::ADDR_WIDTH0,  dpt_pkg::ADDR_WIDTH1:  addr_sel = dpt_pkg::DPT_SEL_WIDTH;
      dpt_pkg::ADDR_COUNT0,  dpt_pkg::ADDR_COUNT1:  addr_sel = dpt_pkg::DPT_SEL_COUNT;
      default:                                      addr_sel = dpt_pkg::DPT_SEL_NONE;
    endcase
  endfunction

  // two identical channels; count register has no write path
  for (genvar i = 0; i < 2; i++) begin : g_ch
    dpt_tmr_if tif ();
    dpt_timer_chan u_chan (
      .clk_in   (core_clk_in),
      .rst_n_in (rst_n_in),
      .tif      (tif.chan)
    );
    assign tif.run       = timer_run_bit_in[i];
    assign tif.wave_mode = output_mode_select_in[i];
    assign tif.polarity  = edge_polarity_select_in[i];
    assign tif.cap_sel   = capture_select_bit_in[i];
    assign tif.pin_in    = timer_event_pin_in[i];
    assign tif.wdata     = iop_wdata_in;
    assign tif.wr_per    = iop_wr_in && (addr_chan(iop_addr_in) == 1'(i)) &&
                           (addr_sel(iop_addr_in) == dpt_pkg::DPT_SEL_PERIOD);
    assign tif.wr_wid    = iop_wr_in && (addr_chan(iop_addr_in) == 1'(i)) &&
                           (addr_sel(iop_addr_in) == dpt_pkg::DPT_SEL_WIDTH);
    assign ch_per[i]     = tif.per;
    assign ch_wid[i]     = tif.wid;
    assign ch_cnt[i]     = tif.cnt;
    assign ch_exp[i]     = tif.exp_evt;
    assign ch_cap[i]     = tif.cap_evt;
    assign ch_pin[i]     = tif.pin_out;
    assign ch_oe[i]      = tif.pin_oe;
  end

  // registered read; unmapped addresses answer zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (iop_rd_in) begin
      case (addr_sel(iop_addr_in))
        dpt_pkg::DPT_SEL_PERIOD: rdata_d = ch_per[addr_chan(iop_addr_in)];
        dpt_pkg::DPT_SEL_WIDTH:  rdata_d = ch_wid[addr_chan(iop_addr_in)];
        dpt_pkg::DPT_SEL_COUNT:  rdata_d = ch_cnt[addr_chan(iop_addr_in)];
        default:                 rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_comb begin
    sticky_set                     = dpt_pkg::STICKY_STATUS_REG_RST;
    sticky_set[dpt_pkg::STICKY_STATUS_REG_CAP0] = ch_cap[0];
    sticky_set[dpt_pkg::STICKY_STATUS_REG_EXP0] = ch_exp[0];
    sticky_set[dpt_pkg::STICKY_STATUS_REG_CAP1] = ch_cap[1];
    sticky_set[dpt_pkg::STICKY_STATUS_REG_EXP1] = ch_exp[1];
    sticky_d = (sticky_q & ~sticky_clr_in) | sticky_set;
  end

  // irq routing; shared latch bit gets the OR of both timers
  always_comb begin
    hi_irq_d = ((ch_exp[0] | ch_cap[0]) &  vector_select_bit_in[0]) |
               ((ch_exp[1] | ch_cap[1]) &  vector_select_bit_in[1]);
    lo_irq_d = ((ch_exp[0] | ch_cap[0]) & ~vector_select_bit_in[0]) |
               ((ch_exp[1] | ch_cap[1]) & ~vector_select_bit_in[1]);
  end

  // status, read data and irq pulses
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sticky_q <= dpt_pkg::STICKY_STATUS_REG_RST;
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
      hi_irq_q <= 1'b0;
      lo_irq_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
      rdata_q  <= rdata_d;
      rvalid_q <= iop_rd_in;
      hi_irq_q <= hi_irq_d;
      lo_irq_q <= lo_irq_d;
    end
  end

  // outputs; pin level and enable are channel flops
  assign iop_rdata_out           = rdata_q;
  assign iop_rvalid_out          = rvalid_q;
  assign sticky_status_out       = sticky_q;
  assign high_prio_timer_irq_out = hi_irq_q;
  assign low_prio_timer_irq_out  = lo_irq_q;
  assign timer_event_pin_out     = ch_pin;
  assign timer_event_pin_oe_out  = ch_oe;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_sticky_hold: assert property (
    sticky_q[dpt_pkg::STICKY_STATUS_REG_EXP0] && !sticky_clr_in[dpt_pkg::STICKY_STATUS_REG_EXP0]
    |=> sticky_q[dpt_pkg::STICKY_STATUS_REG_EXP0])
    else $error("expiry flag dropped without clear");
  chk_sticky_set: assert property (
    ch_exp[1] |=> sticky_q[dpt_pkg::STICKY_STATUS_REG_EXP1])
    else $error("timer 1 expiry not recorded at its bit");
  chk_capture_set: assert property (
    ch_cap[0] && sticky_clr_in[dpt_pkg::STICKY_STATUS_REG_CAP0] |=> sticky_q[dpt_pkg::STICKY_STATUS_REG_CAP0])
    else $error("capture lost against clear");
  chk_irq_route_hi: assert property (
    (ch_exp[1] || ch_cap[1]) && vector_select_bit_in[1]
    |=> high_prio_timer_irq_out)
    else $error("timer 1 request missed high latch");
  chk_irq_route_lo: assert property (
    (ch_exp[0] || ch_cap[0]) && !vector_select_bit_in[0]
    |=> low_prio_timer_irq_out)
    else $error("timer 0 request missed low latch");
  chk_read_count: assert property (
    iop_rd_in && iop_addr_in == dpt_pkg::ADDR_COUNT0 |=> iop_rvalid_out &&
    iop_rdata_out == $past(ch_cnt[0]))
    else $error("count read returned wrong value");
  chk_unmapped_zero: assert property (
    iop_rd_in && addr_sel(iop_addr_in) == dpt_pkg::DPT_SEL_NONE
    |=> iop_rdata_out == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
  chk_rvalid_pulse: assert property (
    !iop_rd_in |=> !iop_rvalid_out)
    else $error("read valid without a read");
  chk_sticky_spare: assert property (
    sticky_status_out[dpt_pkg::STICKY_STATUS_REG_CAP0-1:0] == 12'h000)
    else $error("sticky bits below the timer flags not zero");
  chk_capture1_set: assert property (
    ch_cap[1] |=> sticky_q[dpt_pkg::STICKY_STATUS_REG_CAP1])
    else $error("timer 1 capture not recorded at its bit");
  chk_irq_route_lo1: assert property (
    (ch_exp[1] || ch_cap[1]) && !vector_select_bit_in[1]
    |=> low_prio_timer_irq_out)
    else $error("timer 1 request missed low latch");
  chk_oe_mode: assert property (
    1'b1 |=> timer_event_pin_oe_out == $past(output_mode_select_in))
    else $error("pin enable does not follow mode select");

endmodule

// file: test/dpt_pin_model.sv
// dpt_pin_model: far side of one event pin, a load or a pulse source
// assumes lengths of at least one cycle; the bench reads the wire back
`timescale 1ns/1ps
module dpt_pin_model (
  // clock
  input  wire logic        clk_in,
  // timer side of the pin
  input  wire logic        oe_in,
  input  wire logic        drv_in,
  // source shape in core cycles
  input  wire logic [15:0] hi_len_in,
  input  wire logic [15:0] lo_len_in,
  // resolved wire level
  output logic             wire_out
);
  logic [15:0] cnt_q = 16'h0000;
  logic        src_q = 1'b0;
  // free running source; a zero high length keeps the line low
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 16'h0001;
    if (cnt_q + 16'h0001 >= (src_q ? hi_len_in : lo_len_in)) begin
      cnt_q <= 16'h0000;
      src_q <= ~src_q & (hi_len_in != 16'h0000);
    end
  end
  // a driving timer wins, otherwise the source owns the line
  assign wire_out = oe_in ? drv_in : src_q;
endmodule

// file: test/tb_dual_pwm_pulse_capture_timer.sv
// tb_dual_pwm_pulse_capture_timer: self-checking bench for dpt_top
// assumes dpt_pkg is compiled first; one pin model per timer
`timescale 1ns/1ps
module tb_dual_pwm_pulse_capture_timer;
  logic        core_clk_in  = 1'b0;
  logic        rst_n_in     = 1'b0;
  logic [7:0]  iop_addr_in  = 8'h00;
  logic        iop_wr_in    = 1'b0;
  logic [31:0] iop_wdata_in = 32'h0;
  logic        iop_rd_in    = 1'b0;
  logic [31:0] iop_rdata_out;
  logic        iop_rvalid_out;
  logic [1:0]  run_bits     = 2'h0;
  logic [1:0]  mode_bits    = 2'h0;
  logic [1:0]  pol_bits     = 2'h0;
  logic [1:0]  csel_bits    = 2'h0;
  logic [1:0]  vsel_bits    = 2'b01;
  logic [15:0] sticky_clr_in = 16'h0;
  logic [15:0] sticky_status_out;
  logic        high_prio_timer_irq_out;
  logic        low_prio_timer_irq_out;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  wire  [1:0]  pin_w;
  logic [15:0] src_hi [2] = '{16'h0010, 16'h0010};
  logic [15:0] src_lo [2] = '{16'h0010, 16'h0010};
  int          miscompares = 0;
  int          tests_run = 0;
  int          seed = 32'hDEA8;

  // 250 MHz core clock
  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end

  dpt_top dpt_top_i (
    .core_clk_in             (core_clk_in),
    .rst_n_in                (rst_n_in),
    .iop_addr_in             (iop_addr_in),
    .iop_wr_in               (iop_wr_in),
    .iop_wdata_in            (iop_wdata_in),
    .iop_rd_in               (iop_rd_in),
    .iop_rdata_out           (iop_rdata_out),
    .iop_rvalid_out          (iop_rvalid_out),
    .timer_run_bit_in        (run_bits),
    .output_mode_select_in   (mode_bits),
    .edge_polarity_select_in (pol_bits),
    .capture_select_bit_in   (csel_bits),
    .vector_select_bit_in    (vsel_bits),
    .sticky_clr_in           (sticky_clr_in),
    .sticky_status_out       (sticky_status_out),
    .high_prio_timer_irq_out (high_prio_timer_irq_out),
    .low_prio_timer_irq_out  (low_prio_timer_irq_out),
    .timer_event_pin_in      (pin_w),
    .timer_event_pin_out     (pin_out),
    .timer_event_pin_oe_out  (pin_oe)
  );

  // one far-side model per event pin
  for (genvar g = 0; g < 2; g++) begin : g_pin
    dpt_pin_model dpt_pin_model_i (
      .clk_in    (core_clk_in),
      .oe_in     (pin_oe[g]),
      .drv_in    (pin_out[g]),
      .hi_len_in (src_hi[g]),
      .lo_len_in (src_lo[g]),
      .wire_out  (pin_w[g])
    );
  end

  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // settle one nanosecond past the edge before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  function automatic logic [7:0] reg_addr(input int i, input int r);
    return dpt_pkg::ADDR_PERIOD0 + 8'(3 * i + r);
  endfunction

  // width follows whichever phase comes after the leading edge
  function automatic logic [31:0] exp_width(input logic pol, input int h, input int l);
    return pol ? 32'(l) : 32'(h);
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    iop_addr_in  <= a;
    iop_wdata_in <= d;
    iop_wr_in    <= 1'b1;
    @(posedge core_clk_in);
    iop_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    iop_addr_in <= a;
    iop_rd_in   <= 1'b1;
    @(posedge core_clk_in);
    iop_rd_in <= 1'b0;
    #1;
    check(32'(iop_rvalid_out), 32'h1);
    d = iop_rdata_out;
  endtask

  task automatic clr_sticky(input int b);
    @(posedge core_clk_in);
    sticky_clr_in[b] <= 1'b1;
    @(posedge core_clk_in);
    sticky_clr_in[b] <= 1'b0;
  endtask

  // bounded wait for a wire level; running out ends the run
  task automatic wait_pin(input int i, input logic lvl);
    int n;
    n = 0;
    while (pin_w[i] !== lvl) begin
      tick(1);
      n++;
      if (n > 4000) begin
        miscompares++;
        conclude();
      end
    end
  endtask

  task automatic run_len(input int i, input logic lvl, output int n);
    n = 0;
    while (pin_w[i] === lvl) begin
      tick(1);
      n++;
      if (n > 4000) begin
        miscompares++;
        conclude();
      end
    end
  endtask

  // main sequence: reset, waveform per timer, then measure in all modes
  initial begin
    int          p, w, n, hi_n, lo_n, h, l, i;
    logic [31:0] c1, c2;
    logic        lvl;
    repeat (16) @(posedge core_clk_in);
    check(32'(sticky_status_out), 32'h0);
    check(32'(pin_oe), 32'h0);
    rst_n_in <= 1'b1;
    tick(2);
    reg_rd(8'h30, c1);
    check(c1, 32'h0);
    for (i = 0; i < 2; i++) begin
      p = 3 + {$random(seed)} % 12;
      w = (i == 0) ? p - 1 : 1 + {$random(seed)} % (p - 1);
      reg_wr(reg_addr(i, 0), 32'(p));
      reg_wr(reg_addr(i, 1), 32'(w));
      reg_rd(reg_addr(i, 1), c1);
      check(c1, 32'(w));
      @(posedge core_clk_in);
      mode_bits[i] <= 1'b1;
      run_bits[i]  <= 1'b1;
      tick(2);
      check(32'(pin_oe[i]), 32'h1);
      wait_pin(i, 1'b1);
      wait_pin(i, 1'b0);
      wait_pin(i, 1'b1);
      run_len(i, 1'b1, n);
      check(32'(n), 32'(p - w));
      run_len(i, 1'b0, n);
      check(32'(n), 32'(w));
      hi_n = 0;
      lo_n = 0;
      repeat (4 * p) begin
        tick(1);
        if (high_prio_timer_irq_out === 1'b1) hi_n++;
        if (low_prio_timer_irq_out === 1'b1) lo_n++;
      end
      check(32'(hi_n), (i == 0) ? 32'h4 : 32'h0);
      check(32'(lo_n), (i == 0) ? 32'h0 : 32'h4);
      @(posedge core_clk_in);
      run_bits[i] <= 1'b0;
      tick(3);
      lvl = pin_w[i];
      reg_rd(reg_addr(i, 2), c1);
      reg_wr(reg_addr(i, 2), ~c1);
      tick(10);
      reg_rd(reg_addr(i, 2), c2);
      check(c2, c1);
      check(32'(pin_w[i]), 32'(lvl));
      check(32'(sticky_status_out[13 + 2 * i]), 32'h1);
      clr_sticky(13 + 2 * i);
      tick(2);
      check(32'(sticky_status_out[13 + 2 * i]), 32'h0);
      @(posedge core_clk_in);
      mode_bits[i] <= 1'b0;
      tick(3);
      check(32'(pin_oe[i]), 32'h0);
    end
    // every polarity and capture-select pairing, phases long enough to tell apart
    for (int k = 0; k < 4; k++) begin
      i = k % 2;
      h = 12 + {$random(seed)} % 30;
      l = 12 + {$random(seed)} % 30;
      @(posedge core_clk_in);
      src_hi[i]    <= 16'(h);
      src_lo[i]    <= 16'(l);
      pol_bits[i]  <= i[0];
      csel_bits[i] <= k[1];
      vsel_bits    <= 2'(k);
      run_bits[i]  <= 1'b1;
      tick(3 * (h + l) + 20);
      reg_wr(reg_addr(i, 0), 32'h0000_1234);
      reg_rd(reg_addr(i, 0), c1);
      check(c1, 32'(h + l));
      reg_rd(reg_addr(i, 1), c1);
      check(c1, exp_width(i[0], h, l));
      // start of the trailing phase, so the clear lands before the next lead
      wait_pin(i, !i[0]);
      wait_pin(i, i[0]);
      tick(9);
      clr_sticky(12 + 2 * i);
      wait_pin(i, !i[0]);
      hi_n = 0;
      lo_n = 0;
      repeat (9) begin
        tick(1);
        if (high_prio_timer_irq_out === 1'b1) hi_n++;
        if (low_prio_timer_irq_out === 1'b1) lo_n++;
      end
      check(32'(sticky_status_out[12 + 2 * i]), 32'(k[1]));
      check(32'(hi_n), 32'(k[1] & k[i]));
      check(32'(lo_n), 32'(k[1] & ~k[i]));
      @(posedge core_clk_in);
      run_bits[i] <= 1'b0;
    end
    conclude();
  end
endmodule
